// ---- dpp_pkg.sv ----
// Package with register map, field layout, reset values and timing constants of the directional power element.
package dpp_pkg;
    // Width of the word address on the register bus.
    localparam int DPP_AW = 3;
    // Byte offsets of the registers.
    localparam logic [4:0] DPP_OFS_CTRL = 5'h00;
    localparam logic [4:0] DPP_OFS_ANGLE = 5'h04;
    localparam logic [4:0] DPP_OFS_SPOWER = 5'h08;
    localparam logic [4:0] DPP_OFS_DELAY = 5'h0c;
    localparam logic [4:0] DPP_OFS_STATUS = 5'h10;
    localparam logic [4:0] DPP_OFS_EVENT = 5'h14;
    // Bit positions in the control register.
    localparam int DPP_CTRL_OP = 0;
    localparam int DPP_CTRL_SO = 1;
    localparam int DPP_CTRL_OVER = 2;
    // Bit positions in the status register.
    localparam int DPP_ST_START = 0;
    localparam int DPP_ST_TRIP = 1;
    localparam int DPP_ST_PICK = 2;
    // Bit positions in the event register.
    localparam int DPP_EV_ST_RISE = 0;
    localparam int DPP_EV_ST_FALL = 1;
    localparam int DPP_EV_TR_RISE = 2;
    localparam int DPP_EV_TR_FALL = 3;
    // Reset value of the control register: operation off, trip enabled, under-power mode.
    localparam logic [2:0] DPP_CTRL_RST = 3'h0;
    // Direction angle in degrees, two's complement, and its limits.
    localparam logic [8:0] DPP_ANGLE_RST = 9'h000;
    localparam logic [8:0] DPP_ANGLE_MIN = 9'h14d;
    localparam logic [8:0] DPP_ANGLE_MAX = 9'h0b4;
    // Start power in tenths of a percent and its limits.
    localparam logic [10:0] DPP_SP_RST = 11'h064;
    localparam logic [10:0] DPP_SP_MIN = 11'h00a;
    localparam logic [10:0] DPP_SP_MAX = 11'h7d0;
    // Trip delay in milliseconds and its limits.
    localparam logic [15:0] DPP_DLY_RST = 16'h00c8;
    localparam logic [15:0] DPP_DLY_MIN = 16'h00c8;
    localparam logic [15:0] DPP_DLY_MAX = 16'hea60;
    // One millisecond and the clock period, both in nanoseconds.
    localparam int DPP_MS_NS = 1000000;
    localparam int DPP_CLK_NS = 10;
    // Fraction bits of the sine and cosine values.
    localparam int DPP_TRIG_FRAC = 14;
    // Half turn in degrees and the constant of the sine approximation.
    localparam int DPP_HALF_TURN = 180;
    localparam int DPP_SIN_K = 40500;
    // Hysteresis divisor: one twentieth of the start power.
    localparam int DPP_HYST_DIV = 20;
endpackage

// ---- dpp_directional_power.sv ----
// Directional power element: power calculation, directional decision, start and trip logic, register slave.
//
// The Avalon-MM slave port and the address map are this design's own decisions.
`timescale 1ns/1ps

module dpp_directional_power #(
    parameter int W = 16,
    parameter int PCT_SCALE = 64,
    parameter int CYC_PER_MS = dpp_pkg::DPP_MS_NS / dpp_pkg::DPP_CLK_NS
) (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic [dpp_pkg::DPP_AW-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic signed [W-1:0] volt_re_in [3],
    input wire logic signed [W-1:0] volt_im_in [3],
    input wire logic signed [W-1:0] curr_re_in [3],
    input wire logic signed [W-1:0] curr_im_in [3],
    input wire logic general_block_in,
    input wire logic supervision_block_in,
    output logic general_start_out,
    output logic general_trip_out,
    output logic start_rise_out,
    output logic start_fall_out,
    output logic trip_rise_out,
    output logic trip_fall_out
);
    import dpp_pkg::*;

    localparam int PW = 2 * W + 3;   // Width of the summed power values.
    localparam int XW = PW + 17;     // Width of the projection products.

    // Approximates sine of an angle in degrees (-270 to 270) scaled by two to the fraction bits.
    function automatic logic signed [15:0] dpp_sin(input logic signed [10:0] a);
        logic [31:0] x;
        logic [31:0] n;
        logic neg;
        x = (a < 0) ? 32'(a + 11'sd360) : 32'(a);
        neg = (x > 32'(DPP_HALF_TURN));
        if (neg) begin
            x = x - 32'(DPP_HALF_TURN);
        end
        n = x * (32'(DPP_HALF_TURN) - x);
        n = ((n << 2) << DPP_TRIG_FRAC) / (32'(DPP_SIN_K) - n);
        return neg ? -16'(n) : 16'(n);
    endfunction

    // Applies byte enables of a bus write to a word.
    function automatic logic [31:0] dpp_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);

    logic [2:0] ctrl;                  // Operation, start-only and over-power mode bits.
    logic signed [8:0] angle;          // Direction angle in degrees.
    logic [10:0] spower;               // Start power in tenths of a percent.
    logic [15:0] delay_ms;             // Trip delay in milliseconds.
    logic [3:0] events;                // Sticky start and trip edge events.
    logic signed [PW-1:0] p_pow;       // Three-phase active power.
    logic signed [PW-1:0] q_pow;       // Three-phase reactive power.
    logic signed [15:0] cos_r;         // Cosine of the direction angle.
    logic signed [15:0] sin_r;         // Sine of the direction angle.
    logic signed [XW-1:0] proj;        // Measured power projected onto the set direction.
    logic signed [XW-1:0] thr;         // Start power in power units.
    logic signed [XW-1:0] thr_eff;     // Threshold including hysteresis.
    logic pick;                        // Directional decision.
    logic next_start;                  // Start value for the next edge.
    logic next_trip;                   // Trip value for the next edge.
    logic [16:0] presc;                // Cycle counter within one millisecond.
    logic [15:0] ms_cnt;               // Milliseconds elapsed since start.
    logic bus_req;                     // A read or write is being presented.
    logic [31:0] rd_word;              // Read data selected by the address.
    logic [4:0] byte_addr;             // Byte address of the access.
    logic [31:0] wr_word;              // Register word after byte enables.

    wire op = ctrl[DPP_CTRL_OP];
    wire start_only = ctrl[DPP_CTRL_SO];
    wire over_mode = ctrl[DPP_CTRL_OVER];

    // Active and reactive power are sums of the per-phase phasor products.
    always_ff @(posedge ref_clk_in) begin
        logic signed [PW-1:0] ps;
        logic signed [PW-1:0] qs;
        ps = '0;
        qs = '0;
        for (int i = 0; i < 3; i++) begin
            ps = ps + PW'(volt_re_in[i] * curr_re_in[i]) + PW'(volt_im_in[i] * curr_im_in[i]);
            qs = qs + PW'(volt_im_in[i] * curr_re_in[i]) - PW'(volt_re_in[i] * curr_im_in[i]);
        end
        if (reset_in) begin
            p_pow <= '0;
            q_pow <= '0;
        end else begin
            p_pow <= ps;
            q_pow <= qs;
        end
    end

    // Direction of the set point, refreshed every cycle from the angle setting.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            cos_r <= 16'sh4000;
            sin_r <= 16'sh0000;
        end else begin
            cos_r <= dpp_sin(11'(angle) + 11'sd90);
            sin_r <= dpp_sin(11'(angle));
        end
    end

    // The boundary is the set of points whose projection equals the start power.
    always_comb begin
        proj = (XW'(p_pow) * XW'(cos_r) + XW'(q_pow) * XW'(sin_r)) >>> DPP_TRIG_FRAC;
        thr = XW'(spower) * XW'(PCT_SCALE);
        thr_eff = thr;
        if (general_start_out && over_mode) begin
            thr_eff = thr - thr / XW'(DPP_HYST_DIV);
        end else if (general_start_out) begin
            thr_eff = thr + thr / XW'(DPP_HYST_DIV);
        end
        pick = over_mode ? (proj > thr_eff) : (proj < thr_eff);
        next_start = op && pick && !general_block_in && !supervision_block_in;
        next_trip = next_start && !start_only && (ms_cnt >= delay_ms);
    end

    // A point beyond the plain threshold must start whatever the hysteresis state, since hysteresis only widens it.
    under_pick_a: assert property (!over_mode && op && proj < thr
        && !general_block_in && !supervision_block_in |=> general_start_out) else $error("under pickup missed");
    over_pick_a: assert property (over_mode && op && proj > thr
        && !general_block_in && !supervision_block_in |=> general_start_out) else $error("over pickup missed");
    under_hyst_a: assert property (general_start_out && !over_mode |-> thr_eff > thr) else $error("no raise");
    over_hyst_a: assert property (general_start_out && over_mode |-> thr_eff < thr) else $error("no lower");

    // Start and trip outputs, with edge event pulses beside them.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            general_start_out <= 1'b0;
            general_trip_out <= 1'b0;
            start_rise_out <= 1'b0;
            start_fall_out <= 1'b0;
            trip_rise_out <= 1'b0;
            trip_fall_out <= 1'b0;
        end else begin
            general_start_out <= next_start;
            general_trip_out <= next_trip;
            start_rise_out <= next_start && !general_start_out;
            start_fall_out <= !next_start && general_start_out;
            trip_rise_out <= next_trip && !general_trip_out;
            trip_fall_out <= !next_trip && general_trip_out;
        end
    end

    block_gate_a: assert property (general_block_in || supervision_block_in |=> !general_start_out) else $error("start while blocked");
    off_quiet_a: assert property (!op |=> !general_start_out && !general_trip_out) else $error("active while off");
    // Trip is registered from the previous cycle's start-only bit, so that is the value to compare with.
    trip_start_a: assert property (general_trip_out |-> general_start_out && !$past(start_only))
        else $error("trip without start");
    only_start_a: assert property (start_only |=> !general_trip_out) else $error("trip in start-only");
    fall_clear_a: assert property ($fell(general_start_out) |-> !general_trip_out && ms_cnt == 0) else $error("fall kept timer");
    edge_event_a: assert property ($rose(general_trip_out) |-> trip_rise_out ##1 !trip_rise_out) else $error("trip event");
    start_event_a: assert property ($fell(general_start_out) |-> start_fall_out && !start_rise_out) else $error("start event");
    trip_seen_c: cover property ($rose(general_trip_out));
    start_under_c: cover property ($rose(general_start_out) && !over_mode);
    start_over_c: cover property ($rose(general_start_out) && over_mode);
    block_drop_c: cover property (general_start_out ##1 general_block_in ##1 !general_start_out);

    // Definite delay timer: counts whole milliseconds while start is present.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in || !next_start) begin
            presc <= '0;
            ms_cnt <= '0;
        end else if (presc == 17'(CYC_PER_MS - 1)) begin
            presc <= '0;
            if (ms_cnt != 16'hffff) begin
                ms_cnt <= ms_cnt + 16'h0001;
            end
        end else begin
            presc <= presc + 17'h00001;
        end
    end

    timer_run_a: assert property (general_start_out && presc == 17'(CYC_PER_MS - 1) && next_start
        && ms_cnt < 16'hffff |=> ms_cnt == $past(ms_cnt) + 16'h0001) else $error("timer stalled");

    // Register bus: waitrequest drops for one cycle, one edge after a request appears.
    assign bus_req = avs_read_in || avs_write_in;
    assign byte_addr = {avs_address_in, 2'b00};
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= 32'h0000_0000;
        end else begin
            avs_waitrequest_out <= !(bus_req && avs_waitrequest_out);
            if (avs_read_in && avs_waitrequest_out) begin
                avs_readdata_out <= rd_word;
            end
        end
    end

    bus_answer_a: assert property (bus_req && avs_waitrequest_out |=> !avs_waitrequest_out) else $error("no answer");

    // Read multiplexer; unmapped addresses read as zero.
    always_comb begin
        unique case (byte_addr)
            DPP_OFS_CTRL: rd_word = 32'(ctrl);
            DPP_OFS_ANGLE: rd_word = 32'(angle);
            DPP_OFS_SPOWER: rd_word = 32'(spower);
            DPP_OFS_DELAY: rd_word = 32'(delay_ms);
            DPP_OFS_STATUS: rd_word = 32'({pick, general_trip_out, general_start_out});
            DPP_OFS_EVENT: rd_word = 32'(events);
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // Settings registers; writes outside the allowed ranges are clamped to the nearest limit.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            ctrl <= DPP_CTRL_RST;
            angle <= DPP_ANGLE_RST;
            spower <= DPP_SP_RST;
            delay_ms <= DPP_DLY_RST;
        end else if (avs_write_in && !avs_waitrequest_out) begin
            unique case (byte_addr)
                DPP_OFS_CTRL: ctrl <= wr_word[2:0];
                DPP_OFS_ANGLE: begin
                    if ($signed(wr_word) < $signed(32'(signed'(DPP_ANGLE_MIN)))) begin
                        angle <= DPP_ANGLE_MIN;
                    end else if ($signed(wr_word) > $signed(32'(DPP_ANGLE_MAX))) begin
                        angle <= DPP_ANGLE_MAX;
                    end else begin
                        angle <= wr_word[8:0];
                    end
                end
                DPP_OFS_SPOWER: spower <= (wr_word < 32'(DPP_SP_MIN)) ? DPP_SP_MIN :
                    (wr_word > 32'(DPP_SP_MAX)) ? DPP_SP_MAX : wr_word[10:0];
                DPP_OFS_DELAY: delay_ms <= (wr_word < 32'(DPP_DLY_MIN)) ? DPP_DLY_MIN :
                    (wr_word > 32'(DPP_DLY_MAX)) ? DPP_DLY_MAX : wr_word[15:0];
                default: ;
            endcase
        end
    end

    // Merged write word, for partial byte writes.
    always_comb begin
        wr_word = dpp_merge(rd_word, avs_writedata_in, avs_byteenable_in);
    end

    // Sticky events: hardware set wins over a write-one-to-clear in the same cycle.
    always_ff @(posedge ref_clk_in) begin
        logic [3:0] clr;
        logic [3:0] set;
        clr = (avs_write_in && !avs_waitrequest_out && byte_addr == DPP_OFS_EVENT)
            ? (avs_writedata_in[3:0] & {4{avs_byteenable_in[0]}}) : 4'h0;
        set = {!next_trip && general_trip_out, next_trip && !general_trip_out,
            !next_start && general_start_out, next_start && !general_start_out};
        if (reset_in) begin
            events <= 4'h0;
        end else begin
            events <= (events & ~clr) | set;
        end
    end

    delay_range_a: assert property (delay_ms >= DPP_DLY_MIN && delay_ms <= DPP_DLY_MAX) else $error("delay range");
    power_range_a: assert property (spower >= DPP_SP_MIN && spower <= DPP_SP_MAX) else $error("power range");
endmodule

// ---- dpp_line_model.sv ----
// Line measurement model that feeds balanced phasors and user blocking flags to the power element.
`timescale 1ns/1ps
module dpp_line_model (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic signed [15:0] level_in,
    input wire logic reactive_in,
    input wire logic [1:0] block_req_in,
    output logic signed [15:0] volt_re_out [3],
    output logic signed [15:0] volt_im_out [3],
    output logic signed [15:0] curr_re_out [3],
    output logic signed [15:0] curr_im_out [3],
    output logic general_block_out,
    output logic supervision_block_out
);
    // Voltage magnitude on every phase, so that power is three times this times the current level.
    localparam logic signed [15:0] VOLT = 16'sh0010;
    // The measurement side refreshes its phasors once a clock; reactive mode turns the voltage by 90 degrees.
    always_ff @(posedge ref_clk_in) begin
        for (int p = 0; p < 3; p++) begin
            volt_re_out[p] <= (reset_in || reactive_in) ? 16'sh0000 : VOLT;
            volt_im_out[p] <= (!reset_in && reactive_in) ? VOLT : 16'sh0000;
            curr_re_out[p] <= reset_in ? 16'sh0000 : level_in;
            curr_im_out[p] <= 16'sh0000;
        end
        general_block_out <= !reset_in && block_req_in[0];
        supervision_block_out <= !reset_in && block_req_in[1];
    end
endmodule

// ---- directional_power_protection_test.sv ----
// Self-checking bench for the directional power element driven by a line measurement model.
`timescale 1ns/1ps
module directional_power_protection_test;
    import dpp_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic wait_q;
    logic signed [15:0] v_re [3];
    logic signed [15:0] v_im [3];
    logic signed [15:0] c_re [3];
    logic signed [15:0] c_im [3];
    logic gblk, sblk, st, tr, sr, sf, trr, trf;
    logic signed [15:0] level = 16'sh0000;
    logic reactive = 1'b0;
    logic [1:0] blk_req = 2'h0;
    int error_cnt = 0;
    int total_checks = 0;
    int cyc = 0;
    int ev [4] = '{0, 0, 0, 0};
    // Millisecond shortened to ten cycles so the minimum delay is 2000 cycles.
    dpp_directional_power #(.CYC_PER_MS(10)) i_dut (.ref_clk_in(clk), .reset_in(rst), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hf),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wait_q), .volt_re_in(v_re), .volt_im_in(v_im),
        .curr_re_in(c_re), .curr_im_in(c_im), .general_block_in(gblk), .supervision_block_in(sblk),
        .general_start_out(st), .general_trip_out(tr), .start_rise_out(sr), .start_fall_out(sf),
        .trip_rise_out(trr), .trip_fall_out(trf));
    dpp_line_model i_line (.ref_clk_in(clk), .reset_in(rst), .level_in(level), .reactive_in(reactive),
        .block_req_in(blk_req), .volt_re_out(v_re), .volt_im_out(v_im), .curr_re_out(c_re),
        .curr_im_out(c_im), .general_block_out(gblk), .supervision_block_out(sblk));
    // Clock of 10 ns period.
    initial begin
        forever #5 clk = ~clk;
    end
    // Event pulses are counted and the run is cut short if it hangs.
    always @(posedge clk) begin
        cyc++;
        if (sr === 1'b1) ev[0]++;
        if (sf === 1'b1) ev[1]++;
        if (trr === 1'b1) ev[2]++;
        if (trf === 1'b1) ev[3]++;
        if (cyc == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end
    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("Checks: %0d, mismatches: %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // One Avalon access, held until waitrequest is sampled low, then released for a cycle.
    task automatic bus(input logic w, input logic [4:0] ofs, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        addr <= ofs[4:2];
        wdata <= d;
        rd <= !w;
        wr <= w;
        @(posedge clk);
        while (wait_q !== 1'b0 && n < 50) begin
            @(posedge clk);
            n++;
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
        if (n >= 50) chk(32'h0, 32'h1, "bus answer");
    endtask
    // Waits a few cycles for start to reach the expected level.
    task automatic wait_start(input logic exp, input string what);
        int n;
        n = 0;
        while (st !== exp && n < 8) begin
            @(posedge clk);
            n++;
        end
        chk({31'h0, st}, {31'h0, exp}, what);
    endtask
    // Checks that start and trip hold given levels for n cycles.
    task automatic hold(input int n, input logic s, input logic t, input string what);
        logic bad;
        bad = 1'b0;
        repeat (n) begin
            @(posedge clk);
            if (st !== s || tr !== t) bad = 1'b1;
        end
        chk({31'h0, bad}, 32'h0, what);
    endtask
    // Turns the element off, sets the load, then applies the control word.
    task automatic setup(input logic [31:0] ctrl, input logic signed [15:0] lv, input logic q);
        logic [31:0] d;
        bus(1'b1, DPP_OFS_CTRL, 32'h0, d);
        level <= lv;
        reactive <= q;
        repeat (4) @(posedge clk);
        bus(1'b1, DPP_OFS_CTRL, ctrl, d);
    endtask
    // Reset values, clamping of settings and an unmapped address.
    task automatic t_regs();
        logic [4:0] ofs [14] = '{DPP_OFS_CTRL, DPP_OFS_ANGLE, DPP_OFS_SPOWER, DPP_OFS_DELAY, 5'h18,
            DPP_OFS_ANGLE, DPP_OFS_ANGLE, DPP_OFS_SPOWER, DPP_OFS_SPOWER, DPP_OFS_DELAY, DPP_OFS_DELAY,
            DPP_OFS_SPOWER, DPP_OFS_DELAY, DPP_OFS_ANGLE};
        logic [31:0] wv [14] = '{0, 0, 0, 0, 32'h7, 32'hffffff38, 32'hb5, 32'h0, 32'h7ff, 32'h5, 32'hffff,
            32'h64, 32'h12c, 32'hffffff9c};
        // The angle reads back sign-extended to the full word.
        logic [31:0] exp [14] = '{0, 0, 32'h64, 32'hc8, 0, 32'hffffff4d, 32'hb4, 32'ha, 32'h7d0, 32'hc8, 32'hea60,
            32'h64, 32'h12c, 32'hffffff9c};
        logic [31:0] q;
        for (int k = 0; k < 14; k++) begin
            if (k >= 4) bus(1'b1, ofs[k], wv[k], q);
            bus(1'b0, ofs[k], 32'h0, q);
            chk(q, exp[k], "register value");
        end
        bus(1'b1, DPP_OFS_ANGLE, 32'h0, q);
        bus(1'b1, DPP_OFS_DELAY, 32'hc8, q);
    endtask
    // Operation off, then under-power start, delayed trip, events and dropout.
    task automatic t_trip();
        int n;
        logic [31:0] q;
        setup(32'h0, 16'sd100, 1'b0);
        hold(20, 1'b0, 1'b0, "operation off");
        bus(1'b1, DPP_OFS_CTRL, 32'h1, q);
        wait_start(1'b1, "under start");
        n = 0;
        while (tr !== 1'b1 && n < 2100) begin
            @(posedge clk);
            n++;
        end
        chk({31'h0, n >= 1990 && n <= 2005}, 32'h1, "trip delay");
        bus(1'b0, DPP_OFS_EVENT, 32'h0, q);
        chk(q, 32'h5, "rise events");
        bus(1'b1, DPP_OFS_EVENT, 32'hf, q);
        bus(1'b0, DPP_OFS_EVENT, 32'h0, q);
        chk(q, 32'h0, "events cleared");
        level <= 16'sd150;
        wait_start(1'b0, "under dropout");
        chk({31'h0, tr}, 32'h0, "trip with start");
        bus(1'b0, DPP_OFS_EVENT, 32'h0, q);
        chk(q, 32'ha, "fall events");
        @(posedge clk);
        chk({ev[0], ev[1], ev[2], ev[3]} === {32'd1, 32'd1, 32'd1, 32'd1}, 32'h1, "event pulses");
    endtask
    // Hysteresis in both modes: 6528 holds under, 6240 holds over, neither starts from idle.
    task automatic t_hyst(input logic [31:0] ctrl, input logic signed [15:0] pk, mid, drop);
        setup(ctrl, pk, 1'b0);
        wait_start(1'b1, "mode start");
        level <= mid;
        hold(10, 1'b1, 1'b0, "hysteresis hold");
        level <= drop;
        wait_start(1'b0, "mode dropout");
        level <= mid;
        hold(10, 1'b0, 1'b0, "no start from idle");
    endtask
    // Each block input removes start and trip; release restarts.
    task automatic t_block();
        for (int b = 0; b < 2; b++) begin
            setup(32'h1, 16'sd100, 1'b0);
            wait_start(1'b1, "start before block");
            blk_req <= 2'(1 << b);
            wait_start(1'b0, "blocked");
            chk({31'h0, tr}, 32'h0, "trip blocked");
            blk_req <= 2'h0;
            wait_start(1'b1, "block released");
        end
    endtask
    // Start-only keeps trip low past the delay; angle and reactive power steer the decision.
    task automatic t_misc();
        logic [31:0] q;
        setup(32'h3, 16'sd100, 1'b0);
        hold(2100, 1'b1, 1'b0, "start only");
        bus(1'b1, DPP_OFS_ANGLE, 32'hb4, q);
        setup(32'h1, 16'sd150, 1'b0);
        wait_start(1'b1, "angle 180 under");
        bus(1'b1, DPP_OFS_ANGLE, 32'h5a, q);
        setup(32'h5, 16'sd150, 1'b1);
        wait_start(1'b1, "reactive over");
        bus(1'b0, DPP_OFS_STATUS, 32'h0, q);
        chk(q, 32'h5, "status word");
    endtask
    // Main sequence: reset for eight cycles, then each scenario.
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_trip();
        t_hyst(32'h1, 16'sd100, 16'sd136, 16'sd150);
        t_hyst(32'h5, 16'sd150, 16'sd130, 16'sd100);
        t_block();
        t_misc();
        print_verdict();
    end
endmodule
